// ### rtl/pfc_pkg.sv
package pfc_pkg;

   // Register addresses on the serial port
   localparam logic [6:0] ADR_ENA_A   = 7'h01;
   localparam logic [6:0] ADR_GAIN    = 7'h02;
   localparam logic [6:0] ADR_ENA_B   = 7'h03;
   localparam logic [6:0] ADR_CAL     = 7'h04;
   localparam logic [6:0] ADR_IEN     = 7'h05;
   localparam logic [6:0] ADR_STAT    = 7'h09;
   localparam logic [6:0] ADR_DIE     = 7'h0A;
   localparam logic [6:0] ADR_REV     = 7'h0B;

   // Reset values
   localparam logic [7:0] RST_ENA_A   = 8'h00;
   localparam logic [7:0] RST_GAIN    = 8'h32;
   localparam logic [7:0] RST_ENA_B   = 8'h00;
   localparam logic [7:0] RST_CAL     = 8'h00;
   localparam logic [7:0] RST_IEN     = 8'h01;
   localparam logic [7:0] RST_STAT    = 8'h00;

   // Identification values, arbitrary
   localparam logic [7:0] DIE_IDENTIFIER_VAL  = 8'hA5;
   localparam logic [7:0] REV_VAL     = 8'h3C;

   // Command word layout
   localparam int         CMD_BITS    = 16;
   localparam int         HDR_BITS    = 8;
   localparam int         CMD_RW_BIT  = 15;
   localparam int         CMD_ADR_MSB = 14;
   localparam int         CMD_ADR_LSB = 8;

   // Field positions
   localparam int         ENA_A_PA    = 0;
   localparam int         ENA_A_TX    = 1;
   localparam int         ENA_A_RX    = 2;
   localparam int         ENA_B_PAOUT = 3;
   localparam int         CAL_TX_BIT  = 1;
   localparam int         CAL_RX_BIT  = 2;
   localparam int         CAL_TXR_BIT = 6;
   localparam int         CAL_RXR_BIT = 7;
   localparam logic [7:0] CAL_WR_MASK = 8'h3F;
   localparam int         FLG_OT_BIT  = 5;
   localparam int         FLG_OC_BIT  = 6;
   localparam int         STAT_SRST   = 0;

   // Signal path configuration
   typedef enum logic [1:0] {
      PFC_PATH_NORMAL = 2'b00,
      PFC_PATH_TXCAL  = 2'b01,
      PFC_PATH_RXCAL  = 2'b10
   } pfc_path_e;

endpackage

// ### rtl/pfc_core.sv
`timescale 1ns/100ps

module pfc_core (
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   output logic            miso,
   input  wire logic       reg_space_sel,
   input  wire logic       power_down_pin,
   input  wire logic       overcurrent_det,
   input  wire logic       temp_above_shut,
   input  wire logic       temp_below_resume,
   output logic [7:0]      ena_a_q,
   output logic [7:0]      gain_q,
   output logic [7:0]      ena_b_q,
   output logic [1:0]      cal_path_q,
   output logic            pa_stage_en_q,
   output logic [7:0]      conv_data_q,
   output logic            irq_n_q,
   output logic            tx_rdy_o_q,
   output logic            tx_rdy_oe_n_q,
   output logic            rx_rdy_o_q,
   output logic            rx_rdy_oe_n_q
);

   // Link side, serial clock domain

   // The serial clock stops between frames, so nothing here may rely
   // on an edge after the last bit; a high frame select clears the
   // counter and both shifters at once.
   logic [4:0]  bit_cnt_q;     // Bits taken in this frame
   logic [14:0] shift_q;       // Incoming bits
   logic [7:0]  hdr_q;         // Direction and address of the frame
   logic [6:0]  obuf_q;        // Outgoing bits still to send
   logic [6:0]  wr_adr_q;      // Write address held for crossing
   logic [7:0]  wr_dat_q;      // Write data held for crossing
   logic        wr_sel_q;      // Register space of the write
   logic        wr_tgl_q;      // Flips once per completed write
   logic [15:0] cmd_word;      // Full command word at last bit
   logic [7:0]  hdr_word;      // Header at eighth bit
   logic        hdr_rd;        // Frame is a read
   logic [6:0]  hdr_adr;       // Frame address
   logic [7:0]  rd_byte;       // Read data for the frame

   // Word and header views include the bit arriving on this edge
   assign cmd_word = {shift_q, mosi};
   assign hdr_word = {shift_q[6:0], mosi};
   assign hdr_rd   = hdr_q[7];
   assign hdr_adr  = hdr_q[6:0];

   // Bit counter and input shift, cleared by the frame select
   // Counter stops at sixteen, so bits past the word are ignored
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_q <= 5'h00;
         shift_q   <= 15'h0000;
         hdr_q     <= 8'h00;
      end else begin
         shift_q <= cmd_word[14:0];
         if (bit_cnt_q != 5'(pfc_pkg::CMD_BITS)) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
         end
         if (bit_cnt_q == 5'(pfc_pkg::HDR_BITS - 1)) begin
            hdr_q <= hdr_word;
         end
      end
   end

   // Completed write word handed to the system clock
   // Only the toggle is synchronised; the word is read once the toggle
   // has crossed, when it no longer moves
   always_ff @(posedge sclk or negedge rstn) begin
      if (!rstn) begin
         wr_adr_q <= 7'h00;
         wr_dat_q <= 8'h00;
         wr_sel_q <= 1'b0;
         wr_tgl_q <= 1'b0;
      end else if (!cs_n && bit_cnt_q == 5'(pfc_pkg::CMD_BITS - 1)
                   && !cmd_word[pfc_pkg::CMD_RW_BIT]) begin
         // Word stays stable until the last bit of the next write frame
         wr_adr_q <= cmd_word[pfc_pkg::CMD_ADR_MSB:pfc_pkg::CMD_ADR_LSB];
         wr_dat_q <= cmd_word[7:0];
         wr_sel_q <= reg_space_sel;
         wr_tgl_q <= ~wr_tgl_q;
      end
   end

   // Output shift on the falling edge
   // First read bit is loaded on the falling edge after the header;
   // later falling edges shift the rest out, then zeros
   // Read data comes from the shadow, frozen for the whole frame
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         miso   <= 1'b0;
         obuf_q <= 7'h00;
      end else if (bit_cnt_q == 5'(pfc_pkg::HDR_BITS)) begin
         miso   <= rd_byte[7];
         obuf_q <= rd_byte[6:0];
      end else begin
         miso   <= obuf_q[6];
         obuf_q <= {obuf_q[5:0], 1'b0};
      end
   end

   // Input synchronisers, system clock

   logic [4:0] in_s1_q;        // First stage
   logic [4:0] in_s2_q;        // Second stage
   logic [4:0] pin_in;         // Raw asynchronous levels
   logic [2:0] wt_q;           // Write toggle sync plus history
   logic       pd_s;           // Shutdown, synchronised
   logic       oc_s;           // Overcurrent, synchronised
   logic       hot_s;          // Above shutdown threshold
   logic       cool_s;         // Below resume threshold
   logic       idle_s;         // Frame select inactive
   logic       wr_go;          // One write arrived

   // Packed from the frame select down to the shutdown pin
   assign pin_in = {cs_n, temp_below_resume, temp_above_shut,
                    overcurrent_det, power_down_pin};
   assign pd_s   = in_s2_q[0];
   assign oc_s   = in_s2_q[1];
   assign hot_s  = in_s2_q[2];
   assign cool_s = in_s2_q[3];
   assign idle_s = in_s2_q[4];
   assign wr_go  = wt_q[1] ^ wt_q[2];

   // Two-stage synchronisers for pins and write toggle
   // Only the second stage feeds logic; the third toggle stage is
   // history for the edge detect. Reset holds the frame select idle,
   // so no false frame start follows reset.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         in_s1_q <= 5'h10;
         in_s2_q <= 5'h10;
         wt_q    <= 3'h0;
      end else begin
         in_s1_q <= pin_in;
         in_s2_q <= in_s1_q;
         wt_q    <= {wt_q[1:0], wr_tgl_q};
      end
   end

   // Register bank
   // Every write arrives through the crossing as one pulse

   logic [7:0] cal_q;          // Frequency and calibration control
   logic [7:0] ien_q;          // Interrupt enable control
   logic [7:0] stat_q;         // Fault flags
   logic       tshut_q;        // Thermal shutdown latched
   logic       wr_ok;          // Write reaches command registers
   logic       wr_conv;        // Write reaches converter register
   logic       soft_rst;       // Device reset requested
   logic       tx_ready;       // Transmit path ready
   logic       rx_ready;       // Receive path ready
   logic [7:0] cal_rd;         // Control read view with status
   logic [1:0] flg_evt;        // Fault events per flag
   logic [1:0] flg_en;         // Flag enables per flag
   logic [1:0] irq_src;        // Enabled and set flags

   // Writes are dropped in shutdown, contents kept
   // A soft reset returns every command-space register to its default at once; the converter register keeps its value
   assign wr_ok    = wr_go && !pd_s && !wr_sel_q;
   assign wr_conv  = wr_go && !pd_s && wr_sel_q;
   assign soft_rst = wr_ok && wr_adr_q == pfc_pkg::ADR_STAT
                     && wr_dat_q[pfc_pkg::STAT_SRST];

   // Path readiness
   // Shutdown forces both paths not ready
   assign tx_ready = ena_a_q[pfc_pkg::ENA_A_PA] && ena_a_q[pfc_pkg::ENA_A_TX]
                     && pa_stage_en_q && !pd_s;
   assign rx_ready = ena_a_q[pfc_pkg::ENA_A_RX] && !pd_s;

   // Control register read view, status in top bits
   // Readiness bits are live status and ignore writes
   assign cal_rd = {rx_ready, tx_ready, cal_q[5:0]};

   // Per-flag pairs: overcurrent in bit one, overtemperature in bit zero
   assign flg_evt = {oc_s, hot_s};
   assign flg_en  = {ien_q[pfc_pkg::FLG_OC_BIT], ien_q[pfc_pkg::FLG_OT_BIT]};
   assign irq_src = flg_en & {stat_q[pfc_pkg::FLG_OC_BIT],
                              stat_q[pfc_pkg::FLG_OT_BIT]};

   // Writable registers
   // The control register keeps its two status bits out of storage
   always_ff @(posedge clk_sys) begin
      if (!rstn || soft_rst) begin
         ena_a_q <= pfc_pkg::RST_ENA_A;
         gain_q  <= pfc_pkg::RST_GAIN;
         ena_b_q <= pfc_pkg::RST_ENA_B;
         cal_q   <= pfc_pkg::RST_CAL;
         ien_q   <= pfc_pkg::RST_IEN;
      end else if (wr_ok) begin
         case (wr_adr_q)
            pfc_pkg::ADR_ENA_A: begin
               ena_a_q <= wr_dat_q;
            end
            pfc_pkg::ADR_GAIN: begin
               gain_q <= wr_dat_q;
            end
            pfc_pkg::ADR_ENA_B: begin
               ena_b_q <= wr_dat_q;
            end
            pfc_pkg::ADR_CAL: begin
               // Status bits are not writable
               cal_q <= wr_dat_q & pfc_pkg::CAL_WR_MASK;
            end
            pfc_pkg::ADR_IEN: begin
               ien_q <= wr_dat_q;
            end
            default: begin
               // Unmapped or read-only, ignored
               ien_q <= ien_q;
            end
         endcase
      end
   end

   // Sticky fault flags, one per fault kind
   // A fault seen with its enable clear changes nothing here; the
   // thermal protection itself acts regardless of the enables
   generate
      for (genvar i = 0; i < 2; i++) begin : g_flag
         localparam int POS = (i == 1) ? pfc_pkg::FLG_OC_BIT : pfc_pkg::FLG_OT_BIT;
         logic clr;        // Host writes zero to this bit
         assign clr = wr_ok && wr_adr_q == pfc_pkg::ADR_STAT && !wr_dat_q[POS];
         always_ff @(posedge clk_sys) begin
            if (!rstn || soft_rst) begin
               stat_q[POS] <= 1'b0;
            end else if (flg_evt[i] && flg_en[i]) begin
               // Set wins over a clear in the same cycle
               stat_q[POS] <= 1'b1;
            end else if (clr) begin
               stat_q[POS] <= 1'b0;
            end
            // Disabled enable leaves the flag as it was
         end
      end
   endgenerate

   // Unused status bits read zero
   // These bits never change, so a soft reset needs no term here
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         stat_q[7]   <= 1'b0;
         stat_q[4:0] <= 5'h00;
      end else begin
         stat_q[7]   <= 1'b0;
         stat_q[4:0] <= 5'h00;
      end
   end

   // Thermal protection with hysteresis, independent of enables
   // Latches at the high threshold and releases only at the low one,
   // so the stage cannot chatter around a single level
   // A soft reset leaves it alone; the temperature alone decides
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tshut_q <= 1'b0;
      end else if (hot_s) begin
         tshut_q <= 1'b1;
      end else if (cool_s) begin
         tshut_q <= 1'b0;
      end
   end

   // Converter data register on the second register space
   // Cleared only by rstn; a soft reset leaves it as it was
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         conv_data_q <= 8'h00;
      end else if (wr_conv) begin
         conv_data_q <= wr_dat_q;
      end
   end

   // Pin outputs: interrupt, ready flags, output stage, path
   // Open-drain pins drive only low: data stays zero and the enable
   // decides, so a ready path releases its pin to the pull-up
   // The interrupt follows any enabled, set flag one cycle later
   // Receive calibration wins when both calibration bits are set
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irq_n_q       <= 1'b1;
         pa_stage_en_q <= 1'b0;
         tx_rdy_o_q    <= 1'b0;
         tx_rdy_oe_n_q <= 1'b0;
         rx_rdy_o_q    <= 1'b0;
         rx_rdy_oe_n_q <= 1'b0;
         cal_path_q    <= pfc_pkg::PFC_PATH_NORMAL;
      end else begin
         irq_n_q       <= !(|irq_src);
         pa_stage_en_q <= ena_b_q[pfc_pkg::ENA_B_PAOUT] && !tshut_q
                          && !hot_s && !pd_s;
         tx_rdy_o_q    <= 1'b0;
         tx_rdy_oe_n_q <= tx_ready;
         rx_rdy_o_q    <= 1'b0;
         rx_rdy_oe_n_q <= rx_ready;
         if (cal_q[pfc_pkg::CAL_RX_BIT]) begin
            cal_path_q <= pfc_pkg::PFC_PATH_RXCAL;
         end else if (cal_q[pfc_pkg::CAL_TX_BIT]) begin
            cal_path_q <= pfc_pkg::PFC_PATH_TXCAL;
         end else begin
            cal_path_q <= pfc_pkg::PFC_PATH_NORMAL;
         end
      end
   end

   // Read shadow for the link

   // A frame reads the shadow, never the live registers, so the byte
   // cannot change while it is shifted out; one entry per register but the identification bytes
   logic [7:0] shd_q [0:5];    // Frozen while a frame runs

   // Shadow follows the registers only between frames
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         shd_q[0] <= pfc_pkg::RST_ENA_A;
         shd_q[1] <= pfc_pkg::RST_GAIN;
         shd_q[2] <= pfc_pkg::RST_ENA_B;
         shd_q[3] <= pfc_pkg::RST_CAL;
         shd_q[4] <= pfc_pkg::RST_IEN;
         shd_q[5] <= pfc_pkg::RST_STAT;
      end else if (idle_s) begin
         shd_q[0] <= ena_a_q;
         shd_q[1] <= gain_q;
         shd_q[2] <= ena_b_q;
         shd_q[3] <= cal_rd;
         shd_q[4] <= ien_q;
         shd_q[5] <= stat_q;
      end
   end

   // Read data select; writes and converter space return zero
   // Identification bytes are constants and never stored
   assign rd_byte =
      (!hdr_rd || reg_space_sel)       ? 8'h00 :
      (hdr_adr == pfc_pkg::ADR_ENA_A)  ? shd_q[0] :
      (hdr_adr == pfc_pkg::ADR_GAIN)   ? shd_q[1] :
      (hdr_adr == pfc_pkg::ADR_ENA_B)  ? shd_q[2] :
      (hdr_adr == pfc_pkg::ADR_CAL)    ? shd_q[3] :
      (hdr_adr == pfc_pkg::ADR_IEN)    ? shd_q[4] :
      (hdr_adr == pfc_pkg::ADR_STAT)   ? shd_q[5] :
      (hdr_adr == pfc_pkg::ADR_DIE)    ? pfc_pkg::DIE_IDENTIFIER_VAL :
      (hdr_adr == pfc_pkg::ADR_REV)    ? pfc_pkg::REV_VAL : 8'h00;

endmodule

// ### testbench/pfc_core_properties.sv
`timescale 1ns/100ps
module pfc_core_props (
   input wire logic       clk_sys,
   input wire logic       rstn,
   input wire logic       cs_n,
   input wire logic       miso,
   input wire logic       power_down_pin,
   input wire logic       overcurrent_det,
   input wire logic       temp_above_shut,
   input wire logic       temp_below_resume,
   input wire logic [7:0] ena_a_q,
   input wire logic [7:0] gain_q,
   input wire logic [7:0] ena_b_q,
   input wire logic [1:0] cal_path_q,
   input wire logic       pa_stage_en_q,
   input wire logic       irq_n_q,
   input wire logic       tx_rdy_o_q,
   input wire logic       tx_rdy_oe_n_q,
   input wire logic       rx_rdy_o_q,
   input wire logic       rx_rdy_oe_n_q
);
   logic [3:0] age_q; // Cycles since a fault pin was high
   logic [3:0] age_d; // Next age, saturating at 15
   logic       tx_ok; // Transmit path ready
   logic       rx_ok; // Receive path ready
   assign age_d = (overcurrent_det || temp_above_shut) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
   assign tx_ok = ena_a_q[0] && ena_a_q[1] && pa_stage_en_q;
   assign rx_ok = ena_a_q[2] && !power_down_pin;
   // Fault age counter
   always_ff @(posedge clk_sys) begin
      age_q <= rstn ? age_d : 4'hF;
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   thermal_off_a: assert property (temp_above_shut [*5] |-> !pa_stage_en_q)
      else $error("output stage on while overheated");
   thermal_hold_a: assert property ((!pa_stage_en_q && !temp_below_resume) [*4] |=> !pa_stage_en_q)
      else $error("output stage resumed too early");
   stage_resume_a: assert property ((temp_below_resume && !temp_above_shut && ena_b_q[3]
      && !power_down_pin) [*6] |-> pa_stage_en_q)
      else $error("output stage did not resume");
   tx_ready_a: assert property ($stable(tx_ok) [*5] |-> tx_rdy_oe_n_q == tx_ok)
      else $error("transmit ready wrong");
   rx_ready_a: assert property ($stable(rx_ok) [*5] |-> rx_rdy_oe_n_q == rx_ok)
      else $error("receive ready wrong");
   drive_low_a: assert property (!tx_rdy_o_q && !rx_rdy_o_q)
      else $error("ready pin driven high");
   irq_cause_a: assert property ($fell(irq_n_q) |-> age_q < 4'h8)
      else $error("interrupt without fault");
   pd_keeps_a: assert property (power_down_pin [*4] |=> $stable(gain_q) && $stable(ena_a_q)
      && $stable(ena_b_q) && !pa_stage_en_q)
      else $error("registers changed in shutdown");
   miso_idle_a: assert property (cs_n && $past(cs_n) |-> !miso)
      else $error("miso active while deselected");
   cal_legal_a: assert property (cal_path_q != 2'b11)
      else $error("illegal path setting");
   cover property ($fell(irq_n_q));
   cover property ($fell(pa_stage_en_q));
   cover property (cal_path_q == pfc_pkg::PFC_PATH_RXCAL);
endmodule

bind pfc_core pfc_core_props u_props (.clk_sys, .rstn, .cs_n, .miso, .power_down_pin,
   .overcurrent_det, .temp_above_shut, .temp_below_resume, .ena_a_q, .gain_q, .ena_b_q,
   .cal_path_q, .pa_stage_en_q, .irq_n_q, .tx_rdy_o_q, .tx_rdy_oe_n_q, .rx_rdy_o_q,
   .rx_rdy_oe_n_q);

// ### testbench/pfc_host_model.sv
`timescale 1ns/100ps
module pfc_host_model (
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   // Idle: clock parked low, deselected
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // One 16-bit frame, MSB first, 80 ns serial clock
   task automatic xfer(input logic [15:0] w, output logic [7:0] r);
      int i;
      r = 8'h00;
      #5 cs_n = 1'b0; // Select just clear of the system clock edge
      #208;
      for (i = 15; i >= 0; i--) begin
         mosi = w[i]; // Change while clock low
         #40 sclk = 1'b1;
         if (i < 8) r = {r[6:0], miso}; // Sample on rising
         #40 sclk = 1'b0;
      end
      #40 cs_n = 1'b1;
      mosi = ~mosi; // Released line shows inverse
      #200;
   endtask
endmodule

// ### testbench/plc_frontend_fault_and_serial_control_tb.sv
`timescale 1ns/100ps
module plc_frontend_fault_and_serial_control_tb;
   typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r0; logic [7:0] r1;} pfc_row_s;
   logic       clk_sys = 1'b0;
   logic       rstn = 1'b0;
   logic       reg_space_sel = 1'b0;
   logic       power_down_pin = 1'b0;
   logic       overcurrent_det = 1'b0;
   logic       temp_above_shut = 1'b0;
   logic       temp_below_resume = 1'b1;
   logic       sclk, cs_n, mosi, miso, pa_stage_en_q, irq_n_q;
   logic       tx_rdy_o_q, tx_rdy_oe_n_q, rx_rdy_o_q, rx_rdy_oe_n_q;
   logic [7:0] ena_a_q, gain_q, ena_b_q, conv_data_q;
   logic [1:0] cal_path_q;
   int         failures = 0;
   int         checked = 0;
   // Address, write data, reset readback, readback after write
   pfc_row_s   rows [10] = '{'{8'h04, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h07, 8'h00, 8'h07},
      '{8'h02, 8'h15, 8'h32, 8'h15}, '{8'h03, 8'h08, 8'h00, 8'h08},
      '{8'h05, 8'h60, 8'h01, 8'h60}, '{8'h09, 8'h00, 8'h00, 8'h00},
      '{8'h0A, 8'h00, 8'hA5, 8'hA5}, '{8'h0B, 8'hFF, 8'h3C, 8'h3C},
      '{8'h0C, 8'h55, 8'h00, 8'h00}, '{8'h3F, 8'hAA, 8'h00, 8'h00}};
   always #25 clk_sys = ~clk_sys;
   pfc_core DUT (.clk_sys, .rstn, .sclk, .cs_n, .mosi, .miso, .reg_space_sel, .power_down_pin,
      .overcurrent_det, .temp_above_shut, .temp_below_resume, .ena_a_q, .gain_q, .ena_b_q,
      .cal_path_q, .pa_stage_en_q, .conv_data_q, .irq_n_q, .tx_rdy_o_q, .tx_rdy_oe_n_q,
      .rx_rdy_o_q, .rx_rdy_oe_n_q);
   pfc_host_model host (.sclk, .cs_n, .mosi, .miso);
   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Register write and checked read
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      host.xfer({1'b0, a[6:0], d}, r);
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      host.xfer({1'b1, a[6:0], 8'h00}, r);
      chk(r, e);
      @(posedge clk_sys);
   endtask
   // Fault pins high for ten cycles; hot keeps resume low afterwards
   task automatic pulse(input logic oc, input logic hot);
      @(posedge clk_sys);
      overcurrent_det <= oc;
      temp_above_shut <= hot;
      temp_below_resume <= !hot;
      cyc(10);
      overcurrent_det <= 1'b0;
      temp_above_shut <= 1'b0;
      cyc(10);
   endtask
   task automatic wrap_up;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #1000000;
      failures++;
      wrap_up();
   end
   // Main sequence
   initial begin
      cyc(5);
      rstn <= 1'b1;
      cyc(4);
      foreach (rows[i]) begin
         rd(rows[i].a, rows[i].r0);
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].r1);
      end
      chk(gain_q, 8'h15);
      chk(ena_b_q, 8'h08);
      wr(8'h04, 8'h02);
      chk({6'h00, cal_path_q}, 8'h01);
      wr(8'h04, 8'h06);
      rd(8'h04, 8'hC6);
      chk({6'h00, cal_path_q}, 8'h02);
      chk({6'h00, tx_rdy_oe_n_q, rx_rdy_oe_n_q}, 8'h03);
      pulse(1'b1, 1'b0);
      chk({7'h00, irq_n_q}, 8'h00);
      rd(8'h09, 8'h40);
      wr(8'h09, 8'h00);
      rd(8'h09, 8'h00);
      chk({7'h00, irq_n_q}, 8'h01);
      wr(8'h05, 8'h20);
      pulse(1'b1, 1'b0);
      chk({7'h00, irq_n_q}, 8'h01);
      rd(8'h09, 8'h00);
      pulse(1'b0, 1'b1);
      chk({7'h00, pa_stage_en_q}, 8'h00);
      chk({7'h00, irq_n_q}, 8'h00);
      rd(8'h09, 8'h20);
      temp_below_resume <= 1'b1;
      cyc(10);
      chk({7'h00, pa_stage_en_q}, 8'h01);
      wr(8'h09, 8'h00);
      chk({7'h00, irq_n_q}, 8'h01);
      wr(8'h05, 8'h00);
      pulse(1'b0, 1'b1);
      chk({6'h00, pa_stage_en_q, irq_n_q}, 8'h01);
      rd(8'h09, 8'h00);
      temp_below_resume <= 1'b1;
      power_down_pin <= 1'b1;
      cyc(10);
      wr(8'h02, 8'hAA);
      power_down_pin <= 1'b0;
      cyc(10);
      rd(8'h02, 8'h15);
      reg_space_sel <= 1'b1;
      cyc(2);
      wr(8'h02, 8'h77);
      rd(8'h02, 8'h00);
      reg_space_sel <= 1'b0;
      chk(conv_data_q, 8'h77);
      rd(8'h02, 8'h15);
      wr(8'h09, 8'h01);
      rd(8'h02, 8'h32);
      rd(8'h05, 8'h01);
      chk(ena_a_q, 8'h00);
      chk({6'h00, tx_rdy_oe_n_q, rx_rdy_oe_n_q}, 8'h00);
      wr(8'h02, 8'h5A);
      chk(gain_q, 8'h5A);
      rstn <= 1'b0;
      cyc(5);
      chk(gain_q, 8'h32);
      chk({7'h00, irq_n_q}, 8'h01);
      rstn <= 1'b1;
      cyc(4);
      rd(8'h05, 8'h01);
      wrap_up();
   end
endmodule
